// ### rtl/regset_top.sv
`timescale 1ns/1ps
// Summary of operation
// - reading micro_pc yields it times 16 as 18 bits, low four bits zero.
// - writing micro_pc keeps source bits 17..4 and drops the four lowest.
// - cstore_limit times 512 is compared with micro_pc to pick fetch memory.
// - micro_base is a 24-bit read/write main-memory bit base for microcode.
// - main-memory fetch address is micro_pc times 16 plus micro_base.
// - the return stack holds 32 entries of 24 bits, last in first out.
// - more than 32 pushes wrap and overwrite the oldest, silently.
// - a pop leaves the stored stack data untouched.
// - call and moves to stack_head push; exit and moves from it pop.
// - gpr_dispatch is 24 bits, moved whole or by nibble, feeding the nibble box.
// - only the four general registers may do memory read, write and swap.
// - dispatch sends all 24 bits of gpr_dispatch as descriptor address.
// - gpr_one is 24 bits, nibble addressable, with shift, rotate and extract.
// - both operands are read/write, feed the adder with carry_bit, and shift.
// - the descriptor is address, unit code, type code and 16-bit span count.
// - the whole descriptor loads, stores or swaps with a pad word at once.
// - descriptor_addr is a free 24-bit bit address, moved as one register.
// - descriptor_meta moves whole, as fields, and span count by nibbles.
// - span_count is a binary length up to 65,535 units.
// - sixteen 48-bit pad words, each also moved as two 24-bit halves.
// - micro_pc is 14 bits, covering 16,384 micro-instructions.
// - micro_pc steps by one on every fetch without an exit or a move into micro_pc in the same cycle.
// - below the scaled limit fetch from control memory, otherwise main memory.
module regset_top
   import regset_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // register moves from the sequencer
   input wire move_req_s move_in,
   input wire shift_req_s shift_in,
   input wire xfer_op_e pad_xfer_in,
   input wire logic [PAD_IDX_W-1:0] pad_xfer_idx_in,
   // sequencing
   input wire logic fetch_in,
   input wire logic call_in,
   input wire logic exit_in,
   input wire logic carry_bit_in,
   // main memory
   input wire xfer_op_e mem_op_in,
   input wire reg_sel_e mem_reg_in,
   input wire logic dispatch_in,
   input wire logic mem_rvalid_in,
   input wire logic [WORD_W-1:0] mem_rdata_in,
   // results
   output logic [DESC_W-1:0] rd_data_out,
   output fetch_s fetch_out,
   output mem_port_s mem_out,
   output logic mem_refused_out,
   // datapath feeds
   output logic [WORD_W-1:0] gpr_dispatch_out,
   output logic [WORD_W-1:0] gpr_one_out,
   output logic [WORD_W-1:0] fbox_opa_out,
   output logic [WORD_W-1:0] fbox_opb_out,
   output logic fbox_carry_out,
   output desc_s descriptor_out,
   output logic [PTR_W-1:0] stack_ptr_out
);

   top_state_s state_reg;
   top_state_s state_next;
   logic [WORD_W-1:0] gpr_val [GPR_COUNT];
   logic [WORD_W-1:0] stack_top;
   logic [DESC_W-1:0] src_raw;
   logic [DESC_W-1:0] wval;
   logic [WORD_W-1:0] meta;
   logic [WORD_W-1:0] meta_merge;
   logic [WORD_W-1:0] span_merge;
   logic [PC_W-1:0] limit_scaled;
   logic [PC_W-1:0] pc_from_src;
   logic [WORD_W-1:0] main_addr;
   logic [WORD_W-1:0] push_data;
   logic [WORD_W-1:0] mem_src;
   logic fetch_main;
   logic mv_wr;
   logic mem_allowed;
   logic push;
   logic pop;

   function automatic logic [NIB_W-1:0] get_nib(input logic [WORD_W-1:0] word, input logic [GROUP_W-1:0] grp);
      logic [NIB_W-1:0] res;
      res = 4'h0;
      if (grp < GROUP_COUNT) begin
         res = word[{grp, 2'h0} +: NIB_W];
      end
      return res;
   endfunction : get_nib

   // a nibble write touches one group and keeps the other five
   function automatic logic [WORD_W-1:0] merge24(input logic [WORD_W-1:0] old, input logic en,
                                                 input logic [GROUP_W-1:0] grp, input logic [WORD_W-1:0] val);
      logic [WORD_W-1:0] res;
      res = val;
      if (en) begin
         res = old;
         if (grp < GROUP_COUNT) begin
            res[{grp, 2'h0} +: NIB_W] = val[NIB_W-1:0];
         end
      end
      return res;
   endfunction : merge24

   assign meta = state_reg.desc[WORD_W-1:0];
   assign mv_wr = move_in.valid && move_in.dst != SEL_NONE;
   assign limit_scaled = PC_W'(state_reg.cstore_limit) << LIMIT_SCALE;
   assign fetch_main = state_reg.micro_pc >= limit_scaled;
   assign main_addr = WORD_W'({state_reg.micro_pc, 4'h0}) + state_reg.micro_base;
   assign pc_from_src = wval[SCALED_PC_W-1:PC_SCALE];
   assign meta_merge = merge24(meta, move_in.group_en, move_in.group, wval[WORD_W-1:0]);
   assign span_merge = merge24(WORD_W'(state_reg.desc.span_count), move_in.group_en, move_in.group,
                               wval[WORD_W-1:0]);

   // source read mux; a stack read returns the top before the pop
   always_comb begin
      src_raw = '0;
      case (move_in.src)
         SEL_MICRO_PC: src_raw = DESC_W'({state_reg.micro_pc, 4'h0});
         SEL_CSTORE_LIMIT: src_raw = DESC_W'(state_reg.cstore_limit);
         SEL_MICRO_BASE: src_raw = DESC_W'(state_reg.micro_base);
         SEL_STACK_HEAD: src_raw = DESC_W'(stack_top);
         SEL_GPR_DISPATCH: src_raw = DESC_W'(gpr_val[0]);
         SEL_GPR_ONE: src_raw = DESC_W'(gpr_val[1]);
         SEL_OPND_FIRST: src_raw = DESC_W'(gpr_val[2]);
         SEL_OPND_SECOND: src_raw = DESC_W'(gpr_val[3]);
         SEL_DESC_ADDR: src_raw = DESC_W'(state_reg.desc.addr);
         SEL_DESC_META: src_raw = DESC_W'(meta);
         SEL_UNIT_CODE: src_raw = DESC_W'(state_reg.desc.unit_code);
         SEL_TYPE_CODE: src_raw = DESC_W'(state_reg.desc.type_code);
         SEL_SPAN_COUNT: src_raw = DESC_W'(state_reg.desc.span_count);
         SEL_PAD_HALF: begin
            if (move_in.pad_half) begin
               src_raw = DESC_W'(state_reg.pad_words[move_in.pad_idx][WORD_W-1:0]);
            end else begin
               src_raw = DESC_W'(state_reg.pad_words[move_in.pad_idx][DESC_W-1:WORD_W]);
            end
         end
         SEL_PAD_WORD: src_raw = state_reg.pad_words[move_in.pad_idx];
         SEL_DESC_FULL: src_raw = state_reg.desc;
         SEL_EXT: src_raw = move_in.ext_data;
         default: src_raw = '0;
      endcase
      wval = src_raw;
      if (move_in.group_en) begin
         wval = DESC_W'(get_nib(src_raw[WORD_W-1:0], move_in.group));
      end
   end

   assign push = call_in || (mv_wr && move_in.dst == SEL_STACK_HEAD);
   assign pop = exit_in || (move_in.valid && move_in.src == SEL_STACK_HEAD);
   assign push_data = (mv_wr && move_in.dst == SEL_STACK_HEAD) ? wval[WORD_W-1:0] : WORD_W'(state_reg.micro_pc);

   always_comb begin
      mem_allowed = 1'b0;
      mem_src = WORD_RST;
      for (int i = 0; i < GPR_COUNT; i++) begin
         if (mem_reg_in == GPR_SEL[i]) begin
            mem_allowed = 1'b1;
            mem_src = gpr_val[i];
         end
      end
   end

   always_comb begin
      state_next = state_reg;
      state_next.fetch.valid = 1'b0;
      state_next.mem = '0;
      state_next.mem_refused = 1'b0;
      state_next.fbox_carry = carry_bit_in;
      if (move_in.valid) begin
         state_next.rd_data = wval;
      end
      if (fetch_in) begin
         state_next.fetch.valid = 1'b1;
         state_next.fetch.from_main = fetch_main;
         state_next.fetch.addr = fetch_main ? main_addr : WORD_W'(state_reg.micro_pc);
         state_next.micro_pc = state_reg.micro_pc + PC_STEP;
      end
      if (exit_in) begin
         state_next.micro_pc = stack_top[PC_W-1:0];
      end
      // a move into micro_pc beats both the step and the return
      if (mv_wr) begin
         case (move_in.dst)
            SEL_MICRO_PC: state_next.micro_pc = pc_from_src;
            SEL_CSTORE_LIMIT: state_next.cstore_limit = wval[LIMIT_W-1:0];
            SEL_MICRO_BASE: state_next.micro_base = wval[WORD_W-1:0];
            SEL_DESC_ADDR: state_next.desc.addr = wval[WORD_W-1:0];
            SEL_DESC_META: state_next.desc[WORD_W-1:0] = meta_merge;
            SEL_UNIT_CODE: state_next.desc.unit_code = wval[NIB_W-1:0];
            SEL_TYPE_CODE: state_next.desc.type_code = wval[NIB_W-1:0];
            SEL_SPAN_COUNT: state_next.desc.span_count = span_merge[SPAN_W-1:0];
            SEL_PAD_HALF: begin
               if (move_in.pad_half) begin
                  state_next.pad_words[move_in.pad_idx][WORD_W-1:0] = wval[WORD_W-1:0];
               end else begin
                  state_next.pad_words[move_in.pad_idx][DESC_W-1:WORD_W] = wval[WORD_W-1:0];
               end
            end
            SEL_PAD_WORD: state_next.pad_words[move_in.pad_idx] = wval;
            SEL_DESC_FULL: state_next.desc = desc_s'(wval);
            default: state_next.micro_pc = state_next.micro_pc;
         endcase
      end
      // the parallel descriptor transfer wins over a move in the same cycle
      case (pad_xfer_in)
         XF_LOAD: state_next.desc = desc_s'(state_reg.pad_words[pad_xfer_idx_in]);
         XF_STORE: state_next.pad_words[pad_xfer_idx_in] = state_reg.desc;
         XF_SWAP: begin
            state_next.desc = desc_s'(state_reg.pad_words[pad_xfer_idx_in]);
            state_next.pad_words[pad_xfer_idx_in] = state_reg.desc;
         end
         default: state_next.desc = state_next.desc;
      endcase
      if (mem_rvalid_in) begin
         state_next.mem_pending = 1'b0;
      end
      if (dispatch_in) begin
         state_next.mem.req = 1'b1;
         state_next.mem.dispatch = 1'b1;
         state_next.mem.addr = gpr_val[0];
         state_next.mem_refused = mem_op_in != XF_NONE;
      end else if (mem_op_in != XF_NONE) begin
         if (mem_allowed) begin
            state_next.mem.req = 1'b1;
            state_next.mem.we = mem_op_in != XF_LOAD;
            state_next.mem.addr = state_reg.desc.addr;
            state_next.mem.wdata = mem_src;
            if (mem_op_in != XF_STORE) begin
               state_next.mem_pending = 1'b1;
               state_next.mem_target = mem_reg_in;
            end
         end else begin
            state_next.mem_refused = 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= TOP_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   // returned memory data beats a move into the same register
   for (genvar i = 0; i < GPR_COUNT; i++) begin : g_gpr
      logic hit_mem;
      logic hit_mv;
      shift_op_e op;
      assign hit_mem = mem_rvalid_in && state_reg.mem_pending && state_reg.mem_target == GPR_SEL[i];
      assign hit_mv = mv_wr && move_in.dst == GPR_SEL[i];
      assign op = (shift_in.target == GPR_SEL[i]) ? shift_in.op : SH_NONE;
      gpr_cell #(
         .SHIFT_OK(i != 0),
         .EXTRACT_OK(i == 1)
      ) u_cell (
         .mclk_in(mclk_in),
         .rst_n_in(rst_n_in),
         .load_in(hit_mem || hit_mv),
         .data_in(hit_mem ? mem_rdata_in : merge24(gpr_val[i], move_in.group_en, move_in.group,
                                                   wval[WORD_W-1:0])),
         .op_in(op),
         .amount_in(shift_in.amount),
         .length_in(shift_in.length),
         .value_out(gpr_val[i])
      );
   end

   addr_stack u_stack (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .push_in(push),
      .pop_in(pop),
      .data_in(push_data),
      .top_out(stack_top),
      .ptr_out(stack_ptr_out)
   );

   assign rd_data_out = state_reg.rd_data;
   assign fetch_out = state_reg.fetch;
   assign mem_out = state_reg.mem;
   assign mem_refused_out = state_reg.mem_refused;
   assign gpr_dispatch_out = gpr_val[0];
   assign gpr_one_out = gpr_val[1];
   assign fbox_opa_out = gpr_val[2];
   assign fbox_opb_out = gpr_val[3];
   assign fbox_carry_out = state_reg.fbox_carry;
   assign descriptor_out = state_reg.desc;

   logic [DESC_W-1:0] pad_sel_word;
   assign pad_sel_word = state_reg.pad_words[pad_xfer_idx_in];

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   a_pc_read_scaled: assert property (move_in.valid && move_in.src == SEL_MICRO_PC && !move_in.group_en
      |=> rd_data_out[3:0] == 4'h0 && rd_data_out[17:4] == $past(state_reg.micro_pc) && rd_data_out[47:18] == '0)
      else $error("micro address read not scaled by 16");
   a_pc_write_drop: assert property (mv_wr && move_in.dst == SEL_MICRO_PC && move_in.src == SEL_EXT
      && !move_in.group_en |=> state_reg.micro_pc == $past(move_in.ext_data[17:4]))
      else $error("micro address write kept wrong bits");
   a_fetch_select: assert property (fetch_in |=> fetch_out.valid
      && fetch_out.from_main == ($past(state_reg.micro_pc) >= 14'($past(state_reg.cstore_limit)) * 14'h0200))
      else $error("fetch memory choice wrong");
   a_main_fetch_addr: assert property (fetch_in && fetch_main
      |=> fetch_out.addr == 24'($past(state_reg.micro_pc)) * 24'h000010 + $past(state_reg.micro_base))
      else $error("main memory fetch address wrong");
   a_pc_step_one: assert property (fetch_in && !exit_in && !(mv_wr && move_in.dst == SEL_MICRO_PC)
      |=> state_reg.micro_pc == $past(state_reg.micro_pc) + 14'h0001)
      else $error("micro address did not step by one");
   a_mem_refuse_other: assert property (mem_op_in != XF_NONE && !mem_allowed && !dispatch_in
      |=> mem_refused_out && !mem_out.req)
      else $error("memory transfer from a non general register");
   a_dispatch_addr: assert property (dispatch_in
      |=> mem_out.req && mem_out.dispatch && !mem_out.we && mem_out.addr == $past(gpr_val[0]))
      else $error("dispatch address wrong");
   a_pad_load_desc: assert property (pad_xfer_in == XF_LOAD || pad_xfer_in == XF_SWAP
      |=> descriptor_out == $past(pad_sel_word))
      else $error("descriptor not loaded from pad word");
   c_main_fetch: cover property (fetch_in && fetch_main);
   c_mem_swap: cover property (mem_op_in == XF_SWAP && mem_allowed && !dispatch_in ##1 mem_rvalid_in);
   c_pad_swap: cover property (pad_xfer_in == XF_SWAP);

endmodule : regset_top

// ### rtl/regset_pkg.sv
package regset_pkg;

   localparam int PC_W = 14;
   localparam int WORD_W = 24;
   localparam int DESC_W = 48;
   localparam int LIMIT_W = 4;
   localparam int NIB_W = 4;
   localparam int SPAN_W = 16;
   localparam int PTR_W = 5;
   localparam int STACK_DEPTH = 32;
   localparam int PAD_DEPTH = 16;
   localparam int PAD_IDX_W = 4;
   localparam int GROUP_W = 3;
   localparam int AMT_W = 5;
   localparam int GPR_COUNT = 4;
   // four always-zero low bits on moves of the micro address
   localparam int PC_SCALE = 4;
   localparam int SCALED_PC_W = 18;
   // nine always-zero low bits on the control-store limit
   localparam int LIMIT_SCALE = 9;

   localparam logic [GROUP_W-1:0] GROUP_COUNT = 3'h6;
   localparam logic [PC_W-1:0] PC_STEP = 14'h0001;
   localparam logic [PTR_W-1:0] PTR_STEP = 5'h01;
   localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;

   typedef enum logic [4:0] {
      SEL_NONE = 5'h00,
      SEL_MICRO_PC = 5'h01,
      SEL_CSTORE_LIMIT = 5'h02,
      SEL_MICRO_BASE = 5'h03,
      SEL_STACK_HEAD = 5'h04,
      SEL_GPR_DISPATCH = 5'h05,
      SEL_GPR_ONE = 5'h06,
      SEL_OPND_FIRST = 5'h07,
      SEL_OPND_SECOND = 5'h08,
      SEL_DESC_ADDR = 5'h09,
      SEL_DESC_META = 5'h0a,
      SEL_UNIT_CODE = 5'h0b,
      SEL_TYPE_CODE = 5'h0c,
      SEL_SPAN_COUNT = 5'h0d,
      SEL_PAD_HALF = 5'h0e,
      SEL_PAD_WORD = 5'h0f,
      SEL_DESC_FULL = 5'h10,
      SEL_EXT = 5'h11
   } reg_sel_e;

   typedef enum logic [2:0] {
      SH_NONE = 3'h0,
      SH_LEFT = 3'h1,
      SH_RIGHT = 3'h2,
      SH_ROL = 3'h3,
      SH_ROR = 3'h4,
      SH_EXTRACT = 3'h5
   } shift_op_e;

   typedef enum logic [1:0] {
      XF_NONE = 2'h0,
      XF_LOAD = 2'h1,
      XF_STORE = 2'h2,
      XF_SWAP = 2'h3
   } xfer_op_e;

   localparam reg_sel_e GPR_SEL [GPR_COUNT] = '{SEL_GPR_DISPATCH, SEL_GPR_ONE, SEL_OPND_FIRST, SEL_OPND_SECOND};

   typedef struct packed {
      logic valid;
      reg_sel_e src;
      reg_sel_e dst;
      logic group_en;
      logic [GROUP_W-1:0] group;
      logic [PAD_IDX_W-1:0] pad_idx;
      logic pad_half;
      logic [DESC_W-1:0] ext_data;
   } move_req_s;

   typedef struct packed {
      shift_op_e op;
      reg_sel_e target;
      logic [AMT_W-1:0] amount;
      logic [AMT_W-1:0] length;
   } shift_req_s;

   typedef struct packed {
      logic valid;
      logic from_main;
      logic [WORD_W-1:0] addr;
   } fetch_s;

   typedef struct packed {
      logic req;
      logic we;
      logic dispatch;
      logic [WORD_W-1:0] addr;
      logic [WORD_W-1:0] wdata;
   } mem_port_s;

   typedef struct packed {
      logic [WORD_W-1:0] addr;
      logic [NIB_W-1:0] unit_code;
      logic [NIB_W-1:0] type_code;
      logic [SPAN_W-1:0] span_count;
   } desc_s;

   typedef struct packed {
      logic [PC_W-1:0] micro_pc;
      logic [LIMIT_W-1:0] cstore_limit;
      logic [WORD_W-1:0] micro_base;
      desc_s desc;
      logic [PAD_DEPTH-1:0][DESC_W-1:0] pad_words;
      logic [DESC_W-1:0] rd_data;
      fetch_s fetch;
      mem_port_s mem;
      reg_sel_e mem_target;
      logic mem_pending;
      logic mem_refused;
      logic fbox_carry;
   } top_state_s;

   typedef struct packed {
      logic [PTR_W-1:0] ptr;
      logic [STACK_DEPTH-1:0][WORD_W-1:0] mem;
   } stack_state_s;

   localparam top_state_s TOP_RST = '0;
   localparam stack_state_s STACK_RST = '0;

endpackage : regset_pkg

// ### rtl/gpr_cell.sv
`timescale 1ns/1ps
module gpr_cell
   import regset_pkg::*;
#(
   parameter bit SHIFT_OK = 1'b1,
   parameter bit EXTRACT_OK = 1'b0
) (
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // load and shift
   input wire logic load_in,
   input wire logic [WORD_W-1:0] data_in,
   input wire shift_op_e op_in,
   input wire logic [AMT_W-1:0] amount_in,
   input wire logic [AMT_W-1:0] length_in,
   // contents
   output logic [WORD_W-1:0] value_out
);

   logic [WORD_W-1:0] value_reg;
   logic [WORD_W-1:0] value_next;
   logic [2*WORD_W-1:0] dbl;
   logic [2*WORD_W-1:0] dbl_rol;
   logic [2*WORD_W-1:0] dbl_ror;
   logic [WORD_W-1:0] mask;

   // rotation works on a doubled copy, so amounts must not exceed 24
   always_comb begin
      dbl = {value_reg, value_reg};
      dbl_rol = dbl << amount_in;
      dbl_ror = dbl >> amount_in;
      mask = ~(WORD_RST - 24'h000001 << length_in);
      value_next = value_reg;
      if (load_in) begin
         value_next = data_in;
      end else if (SHIFT_OK) begin
         case (op_in)
            SH_LEFT: value_next = value_reg << amount_in;
            SH_RIGHT: value_next = value_reg >> amount_in;
            SH_ROL: value_next = dbl_rol[2*WORD_W-1:WORD_W];
            SH_ROR: value_next = dbl_ror[WORD_W-1:0];
            SH_EXTRACT: begin
               if (EXTRACT_OK) begin
                  value_next = (value_reg >> amount_in) & mask;
               end
            end
            default: value_next = value_reg;
         endcase
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         value_reg <= WORD_RST;
      end else begin
         value_reg <= value_next;
      end
   end

   assign value_out = value_reg;

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   a_rotate_left_one: assert property (SHIFT_OK && !load_in && op_in == SH_ROL && amount_in == 5'h01
      |=> value_reg == {$past(value_reg[22:0]), $past(value_reg[23])})
      else $error("rotate left by one gave wrong value");

endmodule : gpr_cell

// ### rtl/addr_stack.sv
`timescale 1ns/1ps
module addr_stack
   import regset_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // stack requests
   input wire logic push_in,
   input wire logic pop_in,
   input wire logic [WORD_W-1:0] data_in,
   // stack view
   output logic [WORD_W-1:0] top_out,
   output logic [PTR_W-1:0] ptr_out
);

   stack_state_s state_reg;
   stack_state_s state_next;

   // pop before push: both in one cycle replace the top entry
   always_comb begin
      state_next = state_reg;
      if (pop_in) begin
         state_next.ptr = state_reg.ptr - PTR_STEP;
      end
      if (push_in) begin
         state_next.ptr = state_next.ptr + PTR_STEP;
         state_next.mem[state_next.ptr] = data_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= STACK_RST;
      end else begin
         state_reg <= state_next;
      end
   end

   assign top_out = state_reg.mem[state_reg.ptr];
   assign ptr_out = state_reg.ptr;

   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rst_n_in);

   a_push_shows_top: assert property (push_in && !pop_in |=> top_out == $past(data_in))
      else $error("pushed word is not on top");
   a_pop_keeps_data: assert property (pop_in && !push_in
      |=> state_reg.ptr == $past(state_reg.ptr) - 5'h01 && state_reg.mem == $past(state_reg.mem))
      else $error("pop changed stack contents");
   a_stack_wrap_round: assert property (push_in && !pop_in && state_reg.ptr == 5'h1f |=> state_reg.ptr == 5'h00)
      else $error("stack position did not wrap");
   c_stack_wrap: cover property (push_in && !pop_in && state_reg.ptr == 5'h1f);

endmodule : addr_stack

// ### tb/mem_model.sv
`timescale 1ns/1ps
module mem_model
   import regset_pkg::*;
(
   // clock and reset
   input wire logic mclk_in,
   input wire logic rst_n_in,
   // memory port
   input wire mem_port_s mem_in,
   output logic rvalid_out,
   output logic [WORD_W-1:0] rdata_out
);
   logic [1:0] lag_reg;
   logic [WORD_W-1:0] addr_reg;
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lag_reg <= 2'h0;
         addr_reg <= 24'h000000;
         rvalid_out <= 1'b0;
         rdata_out <= 24'h000000;
      end else begin
         lag_reg <= {lag_reg[0], mem_in.req & !mem_in.we & !mem_in.dispatch};
         if (mem_in.req) begin
            addr_reg <= mem_in.addr;
         end
         rvalid_out <= lag_reg[1];
         // reads answer with the inverted address; the bus toggles between answers
         rdata_out <= lag_reg[1] ? ~addr_reg : ~rdata_out;
      end
   end
endmodule : mem_model

// ### tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import regset_pkg::*;
   logic mclk_in = 1'b0;
   logic rst_n_in = 1'b0;
   move_req_s move_in = '0;
   shift_req_s shift_in = '0;
   xfer_op_e pad_xfer_in = XF_NONE;
   xfer_op_e mem_op_in = XF_NONE;
   reg_sel_e mem_reg_in = SEL_NONE;
   logic [PAD_IDX_W-1:0] pad_xfer_idx_in = 4'h0;
   logic fetch_in = 1'b0, call_in = 1'b0, exit_in = 1'b0, carry_bit_in = 1'b0, dispatch_in = 1'b0;
   logic mem_rvalid_in, mem_refused_out, fbox_carry_out;
   logic [WORD_W-1:0] mem_rdata_in, gpr_dispatch_out, gpr_one_out, fbox_opa_out, fbox_opb_out, b;
   logic [DESC_W-1:0] rd_data_out, rnd;
   fetch_s fetch_out;
   mem_port_s mem_out;
   desc_s descriptor_out;
   logic [PTR_W-1:0] stack_ptr_out;
   logic [3:0] lim;
   logic [13:0] p;
   int bad_count = 0, checked = 0;
   always #2 mclk_in = ~mclk_in;
   regset_top regset_top_inst (.mclk_in, .rst_n_in, .move_in, .shift_in, .pad_xfer_in, .pad_xfer_idx_in,
      .fetch_in, .call_in, .exit_in, .carry_bit_in, .mem_op_in, .mem_reg_in, .dispatch_in, .mem_rvalid_in,
      .mem_rdata_in, .rd_data_out, .fetch_out, .mem_out, .mem_refused_out, .gpr_dispatch_out, .gpr_one_out,
      .fbox_opa_out, .fbox_opb_out, .fbox_carry_out, .descriptor_out, .stack_ptr_out);
   mem_model mem_model_inst (.mclk_in, .rst_n_in, .mem_in(mem_out), .rvalid_out(mem_rvalid_in),
      .rdata_out(mem_rdata_in));
   task automatic chk(input string n, input logic [DESC_W-1:0] e, g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic mv(input reg_sel_e s, d, input logic [DESC_W-1:0] v);
      move_in <= '{1'b1, s, d, 1'b0, 3'h0, 4'h0, 1'b0, v};
      @(posedge mclk_in);
      move_in.valid <= 1'b0;
      @(posedge mclk_in);
   endtask : mv
   task automatic mr(input xfer_op_e o, input reg_sel_e r);
      mem_op_in <= o;
      mem_reg_in <= r;
      @(posedge mclk_in);
      mem_op_in <= XF_NONE;
      @(negedge mclk_in);
   endtask : mr
   task automatic test_done;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : test_done
   initial begin
      void'($urandom(32'h162a32f8));
      repeat (5) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      @(posedge mclk_in);
      repeat (4) begin
         rnd = 48'({$urandom, $urandom});
         mv(SEL_EXT, SEL_MICRO_PC, rnd);
         mv(SEL_MICRO_PC, SEL_NONE, '0);
         chk("micro_pc", {30'h0, rnd[17:4], 4'h0}, rd_data_out);
      end
      for (int i = 0; i < 3; i++) begin
         lim = 4'($urandom_range(15, 1));
         b = 24'($urandom);
         p = {1'b0, lim, 9'h0} - 14'h1;
         mv(SEL_EXT, SEL_CSTORE_LIMIT, {44'h0, lim});
         mv(SEL_EXT, SEL_MICRO_BASE, {24'h0, b});
         mv(SEL_EXT, SEL_MICRO_PC, {30'h0, p, 4'h0});
         for (int k = 0; k < 2; k++) begin
            fetch_in <= 1'b1;
            @(posedge mclk_in);
            fetch_in <= 1'b0;
            @(negedge mclk_in);
            chk("fetch_valid", 48'h1, {47'h0, fetch_out.valid});
            chk("fetch_main", {47'h0, k[0]}, {47'h0, fetch_out.from_main});
            chk("fetch_addr", {24'h0, k ? {6'h0, p, 4'h0} + b : {10'h0, p}}, {24'h0, fetch_out.addr});
            p++;
            @(posedge mclk_in);
         end
         mv(SEL_MICRO_PC, SEL_NONE, '0);
         chk("micro_pc", {30'h0, p, 4'h0}, rd_data_out);
      end
      for (int i = 0; i < 33; i++) begin
         mv(SEL_EXT, SEL_STACK_HEAD, 48'(i));
      end
      chk("stack_ptr", 48'h1, {43'h0, stack_ptr_out});
      for (int i = 32; i > 29; i--) begin
         mv(SEL_STACK_HEAD, SEL_NONE, '0);
         chk("stack_pop", 48'(i), rd_data_out);
      end
      call_in <= 1'b1;
      @(posedge mclk_in);
      call_in <= 1'b0;
      mv(SEL_EXT, SEL_MICRO_PC, '1);
      exit_in <= 1'b1;
      @(posedge mclk_in);
      exit_in <= 1'b0;
      mv(SEL_MICRO_PC, SEL_NONE, '0);
      chk("exit_pc", {30'h0, p, 4'h0}, rd_data_out);
      mv(SEL_STACK_HEAD, SEL_NONE, '0);
      chk("kept_entry", 48'h1d, rd_data_out);
      rnd = 48'({$urandom, $urandom});
      mv(SEL_EXT, SEL_DESC_ADDR, rnd);
      mr(XF_LOAD, SEL_GPR_ONE);
      chk("mem_req", {24'h1, rnd[23:0]}, {23'h0, mem_out.req, mem_out.addr});
      for (int i = 0; i < 8 && gpr_one_out !== ~rnd[23:0]; i++) @(posedge mclk_in);
      chk("gpr_one", {24'h0, ~rnd[23:0]}, {24'h0, gpr_one_out});
      @(posedge mclk_in);
      mr(XF_STORE, SEL_MICRO_BASE);
      chk("refused", 48'h1, {46'h0, mem_out.req, mem_refused_out});
      @(posedge mclk_in);
      b = rnd[23:0];
      rnd = 48'({$urandom, $urandom});
      mv(SEL_EXT, SEL_PAD_WORD, rnd);
      pad_xfer_in <= XF_SWAP;
      @(posedge mclk_in);
      pad_xfer_in <= XF_NONE;
      mv(SEL_PAD_WORD, SEL_NONE, '0);
      chk("desc_swap", rnd, descriptor_out);
      chk("pad_swap", {b, 24'h0}, rd_data_out);
      carry_bit_in <= 1'b1;
      mv(SEL_EXT, SEL_GPR_DISPATCH, rnd);
      chk("carry", 48'h1, {47'h0, fbox_carry_out});
      chk("gpr_dispatch", {24'h0, rnd[23:0]}, {24'h0, gpr_dispatch_out});
      dispatch_in <= 1'b1;
      @(posedge mclk_in);
      dispatch_in <= 1'b0;
      @(negedge mclk_in);
      chk("dispatch", {22'h3, rnd[23:0]}, {22'h0, mem_out.req, mem_out.dispatch, mem_out.addr});
      @(posedge mclk_in);
      mv(SEL_EXT, SEL_OPND_SECOND, rnd);
      shift_in <= '{SH_ROL, SEL_OPND_SECOND, 5'h01, 5'h00};
      @(posedge mclk_in);
      shift_in <= '0;
      mv(SEL_EXT, SEL_OPND_FIRST, ~rnd);
      chk("rotate", {24'h0, rnd[22:0], rnd[23]}, {24'h0, fbox_opb_out});
      chk("opnd_first", {24'h0, ~rnd[23:0]}, {24'h0, fbox_opa_out});
      test_done();
   end
endmodule : testbench
